/* File: hw/relay_ctrl.sv */
/*
 * Operating-state controller of a two-channel safety relay with a classic
 * Wishbone register slave. Assumes pins from outside the clock domain,
 * one 100 MHz clock and a synchronous active-high reset.
 */
// How it works
// - Configuration writes take effect only in the off state.
// - Power applied moves off to initialization with self-tests.
// - Leave initialization only after self-test pass and switch-on delay.
// - Any detected error enters the error state with outputs safe.
// - Entry to de-energized run samples inputs before any activation.
// - Without start, stay de-energized whatever the safety inputs show; with CTRL_AUTO set the code energizes without a start.
// - Energize only with start condition and both safety inputs active.
// - Start without active safety inputs keeps the outputs de-energized.
// - Synchronization mode blocks energizing unless channels were in time.
// - Interlock mode blocks energizing while interlock condition exists.
// - Input deactivation drops outputs and returns to de-energized run.
// - After a trip a fresh start and renewed activation are needed; with CTRL_AUTO set the code needs only renewed activation.
// - Every state except energized run drives outputs de-energized.
// - Safe state holds all relay outputs off, contacts open.
// - Switch-on delay is 2500 ms before leaving initialization.
// - Outputs drop no later than 20 ms after input request.
// - Outputs energize within 100 ms of a valid activation.
`timescale 1ns/10ps
`default_nettype none
module relay_ctrl
  import relay_pkg::*;
#(
  parameter int unsigned SWON_CYCLES = SWON_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        chan_a_i,
  input  wire logic        chan_b_i,
  input  wire logic        start_i,
  input  wire logic        test_ok_i,
  input  wire logic        fault_i,
  input  wire logic        sync_ok_i,
  input  wire logic        interlock_i,
  input  wire logic        power_ok_i,
  output logic             relay_a_o,
  output logic             relay_b_o,
  output logic      [2:0]  state_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] meta_q;
  logic [PIN_N-1:0] pin_q;

  assign pin_raw = {power_ok_i, interlock_i, sync_ok_i, fault_i,
                    test_ok_i, start_i, chan_b_i, chan_a_i};

  for (genvar i = 0; i < PIN_N; i++) begin : g_sync
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        meta_q[i] <= 1'b0;
        pin_q[i]  <= 1'b0;
      end else if (ce_i) begin
        meta_q[i] <= pin_raw[i];
        pin_q[i]  <= meta_q[i];
      end
    end
  end

  logic inputs_on;
  logic start_q;
  logic start_rise;
  logic power;

  assign inputs_on  = pin_q[PIN_A] && pin_q[PIN_B];
  assign power      = pin_q[PIN_POWER];
  assign start_rise = pin_q[PIN_START] && !start_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_q <= 1'b0;
    end else if (ce_i) begin
      start_q <= pin_q[PIN_START];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  state_type        state_q;
  state_type        state_d;
  logic [CFG_W-1:0] cfg_q;
  logic             ack_q;
  logic             rearm_q;
  logic             eval_q;
  logic             wr_en;

  assign wr_en = cyc_i && stb_i && we_i && !ack_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q <= CFG_RST;
    end else if (ce_i && wr_en && adr_i == CTRL_OFS && sel_i[0]
                 && state_q == ST_OFF) begin
      cfg_q <= dat_i[CFG_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else if (ce_i) begin
      ack_q <= cyc_i && stb_i && !ack_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= '0;
    end else if (ce_i && cyc_i && stb_i && !ack_q) begin
      dat_o <= '0;
      if (adr_i == CTRL_OFS) begin
        dat_o[CFG_W-1:0] <= cfg_q;
      end else if (adr_i == STAT_OFS) begin
        dat_o[STAT_STATE +: 3] <= state_q;
        dat_o[STAT_OUT]        <= relay_a_o;
        dat_o[STAT_REARM]      <= rearm_q;
      end
    end
  end

  assign ack_o = ack_q;

  ////////////////////////////////////////////////////////////////////////////
  // Switch-on delay timer

  delay_if tif ();

  assign tif.start = (state_q == ST_OFF) && power;

  delay_timer #(
    .CYCLES (SWON_CYCLES)
  ) u_timer (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .tif   (tif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Re-arm and entry evaluation

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eval_q <= 1'b0;
    end else if (ce_i) begin
      eval_q <= (state_d == ST_DEEN) && (state_q != ST_DEEN);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rearm_q <= 1'b1;
    end else if (ce_i) begin
      if (state_q == ST_ENER && state_d == ST_DEEN) begin
        rearm_q <= 1'b0;
      end else if (state_q == ST_OFF || !inputs_on) begin
        rearm_q <= 1'b1;
      end
    end
  end

  logic start_ok;
  logic qual_ok;
  logic go;

  assign start_ok = cfg_q[CTRL_AUTO] ? 1'b1 : start_rise;
  assign qual_ok  = (!cfg_q[CTRL_SYNC] || pin_q[PIN_SYNC_OK])
                 && (!cfg_q[CTRL_ILK] || !pin_q[PIN_ILK]);
  assign go = !eval_q && start_ok && inputs_on && qual_ok
           && rearm_q;

  ////////////////////////////////////////////////////////////////////////////
  // State machine

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_OFF: begin
        if (power) begin
          state_d = ST_INIT;
        end
      end
      ST_INIT: begin
        if (pin_q[PIN_FAULT]) begin
          state_d = ST_ERR;
        end else if (pin_q[PIN_TEST_OK] && tif.done) begin
          state_d = ST_DEEN;
        end
      end
      ST_DEEN: begin
        if (pin_q[PIN_FAULT]) begin
          state_d = ST_ERR;
        end else if (go) begin
          state_d = ST_ENER;
        end
      end
      ST_ENER: begin
        if (pin_q[PIN_FAULT]) begin
          state_d = ST_ERR;
        end else if (!inputs_on) begin
          state_d = ST_DEEN;
        end
      end
      ST_ERR: begin
        state_d = ST_ERR;
      end
      default: begin
        state_d = ST_ERR;
      end
    endcase
    if (!power) begin
      state_d = ST_OFF;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_OFF;
    end else if (ce_i) begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Relay drivers and status

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      relay_a_o <= 1'b0;
      relay_b_o <= 1'b0;
    end else if (ce_i) begin
      relay_a_o <= (state_d == ST_ENER);
      relay_b_o <= (state_d == ST_ENER);
    end
  end

  assign state_o = state_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  cfg_locked_a: assert property (
    state_q != ST_OFF |=> $stable(cfg_q))
    else $error("Configuration changed outside off state");

  power_up_a: assert property (
    ce_i && state_q == ST_OFF && power |=> state_q == ST_INIT)
    else $error("Power-on did not start initialization");

  init_exit_a: assert property (
    state_q == ST_INIT && state_d == ST_DEEN
      |-> pin_q[PIN_TEST_OK] && tif.done)
    else $error("Initialization left before tests and delay");

  fault_entry_a: assert property (
    ce_i && power && pin_q[PIN_FAULT] && state_q != ST_OFF
      |=> state_q == ST_ERR)
    else $error("Fault did not reach error state");

  entry_eval_a: assert property (
    state_q != ST_DEEN ##1 state_q == ST_DEEN |-> state_d != ST_ENER)
    else $error("Energized without entry evaluation");

  start_gate_a: assert property (
    state_q == ST_DEEN && !cfg_q[CTRL_AUTO] && !start_rise
      |-> state_d != ST_ENER)
    else $error("Energized without start press");

  inputs_gate_a: assert property (
    state_q == ST_DEEN && !inputs_on |-> state_d != ST_ENER)
    else $error("Energized with inactive safety inputs");

  sync_gate_a: assert property (
    state_q == ST_DEEN && cfg_q[CTRL_SYNC] && !pin_q[PIN_SYNC_OK]
      |-> state_d != ST_ENER)
    else $error("Energized without synchronization");

  ilk_gate_a: assert property (
    state_q == ST_DEEN && cfg_q[CTRL_ILK] && pin_q[PIN_ILK]
      |-> state_d != ST_ENER)
    else $error("Energized during interlock");

  trip_drop_a: assert property (
    ce_i && state_q == ST_ENER && !inputs_on && power && !pin_q[PIN_FAULT]
      |=> state_q == ST_DEEN && !relay_a_o)
    else $error("Trip did not return to de-energized run");

  rearm_need_a: assert property (
    state_q == ST_DEEN && !rearm_q |-> state_d != ST_ENER)
    else $error("Re-energized without renewed activation");

  safe_out_a: assert property (
    state_q != ST_ENER |-> !relay_a_o && !relay_b_o)
    else $error("Outputs on outside energized run");

  resp_time_a: assert property (
    ce_i && relay_a_o && !chan_a_i
      ##1 ce_i [*3] |-> !relay_a_o)
    else $error("Outputs not dropped within response time");

  act_time_a: assert property (
    ce_i && state_q == ST_DEEN && state_d == ST_ENER
      |=> relay_a_o && relay_b_o)
    else $error("Outputs not energized in time");

  power_off_a: assert property (
    ce_i && !power |=> state_q == ST_OFF && !relay_a_o)
    else $error("Power loss did not reach off state");

  err_hold_a: assert property (
    state_q == ST_ERR && power |=> state_q == ST_ERR)
    else $error("Error state left without power cycle");

  cv_energize_c: cover property (
    state_q == ST_DEEN ##1 state_q == ST_ENER);
  cv_trip_c: cover property (
    state_q == ST_ENER ##1 state_q == ST_DEEN);
  cv_error_c: cover property (state_q == ST_ERR);
  cv_reenergize_c: cover property (
    state_q == ST_ENER ##1 state_q == ST_DEEN ##[1:50] state_q == ST_ENER);

endmodule : relay_ctrl
`default_nettype wire

/* File: hw/relay_pkg.sv */
/*
 * Shared constants of the safety relay state controller: register map,
 * field positions, state codes and timing counts.
 * Assumes a 100 MHz system clock.
 */
package relay_pkg;

  // Clock and times
  localparam int unsigned CLK_KHZ     = 100000;
  localparam int unsigned SWON_MS     = 2500;
  localparam int unsigned RESP_MS     = 20;
  localparam int unsigned ACT_MS      = 100;
  localparam int unsigned SWON_CYC    = SWON_MS * CLK_KHZ;
  localparam int unsigned RESP_CYC    = RESP_MS * CLK_KHZ;
  localparam int unsigned ACT_CYC     = ACT_MS * CLK_KHZ;
  localparam int unsigned TMR_W       = 28;

  // Register map, byte addresses
  localparam logic [3:0] CTRL_OFS     = 4'h0;
  localparam logic [3:0] STAT_OFS     = 4'h4;

  // Control fields
  localparam int unsigned CTRL_AUTO   = 0;
  localparam int unsigned CTRL_SYNC   = 1;
  localparam int unsigned CTRL_ILK    = 2;
  localparam int unsigned CFG_W       = 3;
  localparam logic [2:0]  CFG_RST     = 3'h0;

  // Status fields
  localparam int unsigned STAT_STATE  = 0;
  localparam int unsigned STAT_OUT    = 3;
  localparam int unsigned STAT_REARM  = 4;

  // Pin vector positions
  localparam int unsigned PIN_A       = 0;
  localparam int unsigned PIN_B       = 1;
  localparam int unsigned PIN_START   = 2;
  localparam int unsigned PIN_TEST_OK = 3;
  localparam int unsigned PIN_FAULT   = 4;
  localparam int unsigned PIN_SYNC_OK = 5;
  localparam int unsigned PIN_ILK     = 6;
  localparam int unsigned PIN_POWER   = 7;
  localparam int unsigned PIN_N       = 8;

  // Operating states, Gray along the usual path
  typedef enum logic [2:0] {
    ST_OFF  = 3'h0,
    ST_INIT = 3'h1,
    ST_DEEN = 3'h3,
    ST_ENER = 3'h2,
    ST_ERR  = 3'h6
  } state_type;

endpackage : relay_pkg

/* File: hw/delay_if.sv */
/*
 * Handshake between the state controller and its delay timer.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
interface delay_if;
  logic start;
  logic done;
  modport ctl   (output start, input done);
  modport timer (input start, output done);
endinterface : delay_if
`default_nettype wire

/* File: hw/delay_timer.sv */
/*
 * Down counter for the switch-on delay; start reloads, done is a level.
 * Assumes a synchronous active-high reset and a clock enable.
 */
`timescale 1ns/10ps
`default_nettype none
module delay_timer
  import relay_pkg::*;
#(
  parameter int unsigned CYCLES = SWON_CYC
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  delay_if.timer    tif
);

  logic [TMR_W-1:0] cnt_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (ce_i) begin
      if (tif.start) begin
        cnt_q <= TMR_W'(CYCLES - 1);
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  assign tif.done = (cnt_q == '0) && !tif.start;

endmodule : delay_timer
`default_nettype wire

/* File: tb/estop_model.sv */
/*
 * Partner model: two-channel emergency stop contacts and start button.
 * Assumes the bench commands it by non-blocking assignment at clock edges.
 */
`timescale 1ns/10ps
`default_nettype none
module estop_model (
  input  wire logic [1:0] pull_i,
  input  wire logic       press_i,
  output logic            chan_a_o,
  output logic            chan_b_o,
  output logic            start_o
);
  // Contacts close while the actuator is pulled out
  assign chan_a_o = pull_i[0];
  assign chan_b_o = pull_i[1];
  // Operator gives each fresh press and re-activation
  assign start_o  = press_i;
endmodule : estop_model
`default_nettype wire

/* File: tb/safety_relay_state_machine_bench.sv */
/*
 * Self-checking bench of the relay state controller.
 * Assumes a shortened switch-on delay and the partner model beside it.
 */
`timescale 1ns/10ps
`default_nettype none
module safety_relay_state_machine_bench;
  import relay_pkg::*;
  localparam int unsigned SWON = 20;
  logic        clk_i   = 1'b0;
  logic        rst_i   = 1'b1;
  logic        ce      = 1'b1;
  logic [3:0]  sel     = 4'hf;
  logic        cyc     = 1'b0;
  logic        stb     = 1'b0;
  logic        we      = 1'b0;
  logic        power   = 1'b0;
  logic        test_ok = 1'b1;
  logic        fault   = 1'b0;
  logic        sync_ok = 1'b1;
  logic        ilk     = 1'b0;
  logic        press   = 1'b0;
  logic [1:0]  pull    = 2'h0;
  logic [3:0]  adr     = 4'h0;
  logic [31:0] wdat    = 32'h0;
  logic [31:0] rnd     = 32'h4e00;
  logic [31:0] q;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        chan_a;
  logic        chan_b;
  logic        start;
  logic        ra;
  logic        rb;
  logic [2:0]  state_o;
  int          mismatches = 0;
  int          n_checks   = 0;

  always #5 clk_i = ~clk_i;

  estop_model ops (.pull_i(pull), .press_i(press), .chan_a_o(chan_a),
                   .chan_b_o(chan_b), .start_o(start));
  relay_ctrl #(.SWON_CYCLES(SWON)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o),
    .ack_o(ack_o), .chan_a_i(chan_a), .chan_b_i(chan_b), .start_i(start),
    .test_ok_i(test_ok), .fault_i(fault), .sync_ok_i(sync_ok),
    .interlock_i(ilk), .power_ok_i(power), .relay_a_o(ra),
    .relay_b_o(rb), .state_o(state_o));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict

  task automatic cyc_n(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc_n

  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack_o !== 1'b1) begin
      mismatches++;
      give_verdict();
    end
  endtask : wb

  // Model: relays energized only in the energized run state
  task automatic exp_st(input state_type s);
    check("state", {29'h0, state_o}, {29'h0, s});
    check("relays", {30'h0, ra, rb}, (s == ST_ENER) ? 32'h3 : 32'h0);
  endtask : exp_st

  task automatic push;
    @(posedge clk_i);
    press <= 1'b1;
    cyc_n(2);
    press <= 1'b0;
    cyc_n(4);
  endtask : push

  ////////////////////////////////////////////////////////////////////////
  initial begin
    cyc_n(5000);
    mismatches++;
    give_verdict();
  end

  initial begin
    cyc_n(5);
    rst_i <= 1'b0;
    cyc_n(2);
    exp_st(ST_OFF);
    wb(1'b1, CTRL_OFS, 32'h6, q);
    wb(1'b0, CTRL_OFS, 32'h0, q);
    check("ctrl", q, 32'h6);
    wb(1'b0, 4'h8, 32'h0, q);
    check("unmapped", q, 32'h0);
    power <= 1'b1;
    cyc_n(8);
    exp_st(ST_INIT);
    rnd = lfsr(rnd);
    wb(1'b1, CTRL_OFS, rnd, q);
    wb(1'b0, CTRL_OFS, 32'h0, q);
    check("ctrl", q, 32'h6);
    cyc_n(SWON);
    exp_st(ST_DEEN);
    $display("test power on done");
    push;
    exp_st(ST_DEEN);
    pull <= 2'h3;
    cyc_n(6);
    exp_st(ST_DEEN);
    push;
    exp_st(ST_ENER);
    wb(1'b0, STAT_OFS, 32'h0, q);
    check("status", q, 32'h1a);
    pull <= 2'h2;
    cyc_n(4);
    exp_st(ST_DEEN);
    pull <= 2'h3;
    cyc_n(6);
    exp_st(ST_DEEN);
    push;
    exp_st(ST_ENER);
    $display("test start and trip done");
    // Clock enable low freezes state and pins
    ce   <= 1'b0;
    pull <= 2'h0;
    cyc_n(6);
    exp_st(ST_ENER);
    ce <= 1'b1;
    cyc_n(5);
    exp_st(ST_DEEN);
    $display("test clock enable done");
    for (int i = 0; i < 3; i++) begin
      pull <= 2'h0;
      cyc_n(5);
      exp_st(ST_DEEN);
      sync_ok <= (i != 0);
      ilk     <= (i == 1);
      pull    <= 2'h3;
      cyc_n(6);
      push;
      exp_st((i == 2) ? ST_ENER : ST_DEEN);
    end
    $display("test sync and interlock done");
    fault <= 1'b1;
    cyc_n(5);
    exp_st(ST_ERR);
    fault <= 1'b0;
    push;
    exp_st(ST_ERR);
    power <= 1'b0;
    cyc_n(5);
    exp_st(ST_OFF);
    sel <= 4'he;
    wb(1'b1, CTRL_OFS, 32'h1, q);
    sel <= 4'hf;
    wb(1'b0, CTRL_OFS, 32'h0, q);
    check("ctrl", q, 32'h6);
    wb(1'b1, CTRL_OFS, 32'h1, q);
    power <= 1'b1;
    cyc_n(SWON + 3);
    exp_st(ST_INIT);
    cyc_n(9);
    exp_st(ST_ENER);
    $display("test error and auto start done");
    give_verdict();
  end
endmodule : safety_relay_state_machine_bench
`default_nettype wire
